// file: design/aot_defs.vh
// Constants for the converter output timing block.
// Assumes a 40 MHz system clock; all times are turned into cycle counts here.
`ifndef AOT_DEFS_VH
`define AOT_DEFS_VH

// Result word layout
`define AOT_WIDTH            14
`define AOT_SIGN_BIT         13
`define AOT_CODE_MOST_NEG    14'h2000
`define AOT_CODE_MOST_POS    14'h1fff
`define AOT_RESET_WORD       14'h0000

// Clock period and timing figures
`define AOT_CLK_PERIOD_PS    25000
`define AOT_CONV_TIME_NS     100
`define AOT_REFRESH_TIME_US  1000

// Conversion time in cycles, rounded up, never below one
`define AOT_CONV_CYCLES      (((`AOT_CONV_TIME_NS * 1000) + `AOT_CLK_PERIOD_PS - 1) / `AOT_CLK_PERIOD_PS)
// Idle time before a refresh, in cycles
`define AOT_REFRESH_CYCLES   ((`AOT_REFRESH_TIME_US * 1000000) / `AOT_CLK_PERIOD_PS)

// Counter widths
`define AOT_CONV_CNT_W       3
`define AOT_IDLE_CNT_W       16

`endif

// file: design/aot_adc_output.v
// Output timing of a 14-bit pipelined sampling converter: conversion start,
// pipeline delay, result word, out-of-range flag, status and idle refresh.
// Assumes the conversion clock and the sample word arrive asynchronously on pins.
// Assumes the sample word is held steady while the conversion clock pin is high,
// and that the pin period exceeds about five system clock cycles.
//
// Summary of operation
// - Each rising edge of the conversion clock seen while acquiring samples the input and starts a conversion; falling edges do nothing.
// - A started conversion always runs to its end and no edge can abort or restart it meanwhile.
// - The result outputs are updated at the end of each conversion, about 150 to 175ns after its starting edge.
// - A sample's result appears at the end of the second conversion started after its own, two accepted starts later.
// - Results are 14-bit two's complement words with the sign in the top bit.
// - The out-of-range flag is high exactly when the word is the most negative or most positive code.
// - The status output is low during a conversion and high while acquiring afterwards.
// - After 1ms without a rising clock edge an internal timer refreshes the dynamic logic.
`timescale 1ns/1ps
`include "aot_defs.vh"

module aot_adc_output #(
   parameter REFRESH_CYCLES = `AOT_REFRESH_CYCLES
) (
   input  wire                   clock_in,
   input  wire                   sys_rst_in,
   input  wire                   conv_clk_in,
   input  wire [`AOT_WIDTH-1:0]  sample_in,
   output wire [`AOT_WIDTH-1:0]  result_bits_out,
   output wire                   out_of_range_flag_out,
   output wire                   acquiring_out,
   output wire                   refresh_out
);

   // Last counts of the two timers, cut to the counter widths on purpose
   localparam integer               CONV_LAST_I = `AOT_CONV_CYCLES - 1;
   localparam integer               IDLE_LAST_I = REFRESH_CYCLES - 1;
   localparam [`AOT_CONV_CNT_W-1:0] CONV_LAST   = CONV_LAST_I[`AOT_CONV_CNT_W-1:0];
   localparam [`AOT_IDLE_CNT_W-1:0] IDLE_LAST   = IDLE_LAST_I[`AOT_IDLE_CNT_W-1:0];

   // Conversion states, one-hot
   localparam [1:0] ST_ACQ  = 2'b01;
   localparam [1:0] ST_CONV = 2'b10;

   // Pin synchronisers and edge detector
   reg                        clk_meta_q;
   reg                        clk_sync_q;
   reg                        clk_prev_q;
   reg  [`AOT_WIDTH-1:0]      smp_meta_q;
   reg  [`AOT_WIDTH-1:0]      smp_sync_q;
   wire                       rise;
   // Conversion control
   reg  [1:0]                 state_q;
   reg  [1:0]                 state_d;
   reg  [`AOT_CONV_CNT_W-1:0] conv_cnt_q;
   reg  [`AOT_CONV_CNT_W-1:0] conv_cnt_d;
   wire                       start;
   wire                       conv_done;
   // Sample pipeline and outputs
   reg  [`AOT_WIDTH-1:0]      stage0_q;
   reg  [`AOT_WIDTH-1:0]      stage1_q;
   reg  [`AOT_WIDTH-1:0]      stage2_q;
   reg  [`AOT_WIDTH-1:0]      result_q;
   reg  [`AOT_WIDTH-1:0]      result_d;
   reg                        oor_q;
   reg                        oor_d;
   reg                        acq_q;
   // Idle refresh
   reg  [`AOT_IDLE_CNT_W-1:0] idle_cnt_q;
   reg  [`AOT_IDLE_CNT_W-1:0] idle_cnt_d;
   reg                        refresh_q;
   reg                        refresh_d;

   // True for the two extreme codes of a two's complement word
   function is_extreme;
      input [`AOT_WIDTH-1:0] word;
      begin
         is_extreme = (word == `AOT_CODE_MOST_NEG) || (word == `AOT_CODE_MOST_POS);
      end
   endfunction

   // Timing of one accepted start, E being the edge that sees the rise:
   //   E       sample enters stage0, pipeline shifts, status drops
   //   E+1     conversion timer starts counting
   //   E+4     timer at its last count: result and flag load stage2, status rises
   // The pin rise reaches E two to three system edges after it happens, through
   // the synchroniser and the edge detector, so the pin period must exceed about
   // four system cycles plus that jitter or a start is silently dropped.
   // The pipeline advances only on accepted starts: edges seen while busy are
   // dropped without a shift, which keeps each result paired with its sample.

   // Two-flop synchronisers for the pin inputs
   // The sample word is taken only on a detected rise, after it has crossed
   // with the pin, so it has settled if it is held while the pin is high
   // The previous synchronised pin level feeds the rising-edge detector
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         clk_meta_q <= 1'b0;
         clk_sync_q <= 1'b0;
         clk_prev_q <= 1'b0;
         smp_meta_q <= `AOT_RESET_WORD;
         smp_sync_q <= `AOT_RESET_WORD;
      end else begin
         clk_meta_q <= conv_clk_in;
         clk_sync_q <= clk_meta_q;
         clk_prev_q <= clk_sync_q;
         smp_meta_q <= sample_in;
         smp_sync_q <= smp_meta_q;
      end
   end

   // Only the rising edge counts
   assign rise      = clk_sync_q & ~clk_prev_q;
   // Edges during a running conversion are ignored
   assign start     = rise & state_q[0];
   // Last count of the conversion timer ends the conversion
   assign conv_done = state_q[1] & (conv_cnt_q == CONV_LAST);

   // Conversion state machine
   // An illegal state code falls back to acquiring, so a disturbed state
   // register can never leave the converter stuck busy
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_ACQ: begin
            if (start) begin
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               state_d = ST_ACQ;
            end
         end
         default: begin
            state_d = ST_ACQ;
         end
      endcase
   end

   // Next values of the conversion timer and the idle timer
   always @* begin
      conv_cnt_d = conv_cnt_q;
      idle_cnt_d = idle_cnt_q + 1'b1;
      refresh_d  = 1'b0;
      // Conversion timer restarts on an accepted start and runs while busy
      if (start) begin
         conv_cnt_d = {`AOT_CONV_CNT_W{1'b0}};
      end else if (state_q[1]) begin
         conv_cnt_d = conv_cnt_q + 1'b1;
      end
      // Any rise, accepted or not, restarts the idle timer
      if (rise) begin
         idle_cnt_d = {`AOT_IDLE_CNT_W{1'b0}};
      end else if (idle_cnt_q == IDLE_LAST) begin
         idle_cnt_d = {`AOT_IDLE_CNT_W{1'b0}};
         refresh_d  = 1'b1;
      end
   end

   // State, conversion timer and sample pipeline
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q    <= ST_ACQ;
         conv_cnt_q <= {`AOT_CONV_CNT_W{1'b0}};
         stage0_q   <= `AOT_RESET_WORD;
         stage1_q   <= `AOT_RESET_WORD;
         stage2_q   <= `AOT_RESET_WORD;
      end else begin
         state_q    <= state_d;
         conv_cnt_q <= conv_cnt_d;
         if (start) begin
            stage0_q   <= smp_sync_q;
            stage1_q   <= stage0_q;
            stage2_q   <= stage1_q;
         end
      end
   end

   // Next result and flag: both load together at the end of a conversion
   always @* begin
      result_d = result_q;
      oor_d    = oor_q;
      if (conv_done) begin
         result_d = stage2_q;
         oor_d    = is_extreme(stage2_q);
      end
   end

   // Result and flag update together at the end of conversion; status follows the next state
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         result_q <= `AOT_RESET_WORD;
         oor_q    <= 1'b0;
         acq_q    <= 1'b1;
      end else begin
         acq_q    <= state_d[0];
         result_q <= result_d;
         oor_q    <= oor_d;
      end
   end

   // Idle timer refreshes dynamic logic when the clock stops
   // While the clock stays stopped the pulse repeats; it touches no data
   // and no pipeline stage, so a stopped converter keeps its last result
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         idle_cnt_q <= {`AOT_IDLE_CNT_W{1'b0}};
         refresh_q  <= 1'b0;
      end else begin
         idle_cnt_q <= idle_cnt_d;
         refresh_q  <= refresh_d;
      end
   end

   // Every output comes straight from its flip-flop
   assign result_bits_out       = result_q;
   assign out_of_range_flag_out = oor_q;
   assign acquiring_out         = acq_q;
   assign refresh_out           = refresh_q;

endmodule // aot_adc_output

// file: sim/aot_adc_checker.sv
// Checker for the converter output timing block.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`include "aot_defs.vh"
module aot_adc_checker #(parameter REFRESH_CYCLES = `AOT_REFRESH_CYCLES) (
   input wire                  clock_in,
   input wire                  sys_rst_in,
   input wire                  conv_clk_in,
   input wire [`AOT_WIDTH-1:0] result_bits_out,
   input wire                  out_of_range_flag_out,
   input wire                  acquiring_out,
   input wire                  refresh_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   // Conversion start, length and result update
   start_lat_a: assert property ($rose(conv_clk_in) && acquiring_out |-> ##[2:5] !acquiring_out)
      else $error("no start");
   conv_len_a: assert property ($fell(acquiring_out) |=> !acquiring_out[*3] ##1 acquiring_out)
      else $error("bad length");
   result_upd_a: assert property ($changed(result_bits_out) |-> $rose(acquiring_out))
      else $error("word moved");
   flag_match_a: assert property (out_of_range_flag_out == (result_bits_out == 14'h2000 || result_bits_out == 14'h1fff))
      else $error("bad flag");
   flag_sync_a: assert property ($changed(out_of_range_flag_out) |-> $changed(result_bits_out))
      else $error("flag moved");
   // Status after reset and idle refresh
   reset_state_a: assert property ($fell(sys_rst_in) |-> acquiring_out && !refresh_out
      && !out_of_range_flag_out && result_bits_out == 14'h0000)
      else $error("bad reset");
   refresh_pulse_a: assert property (refresh_out |=> !refresh_out)
      else $error("long refresh");
   refresh_quiet_a: assert property ($rose(conv_clk_in) |-> ##3 !refresh_out[*8])
      else $error("early refresh");
   // Cycles since the conversion clock pin last rose, saturating
   reg        pin_q;
   reg [15:0] quiet_q;
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_q   <= 1'b0;
         quiet_q <= 16'h0000;
      end else begin
         pin_q <= conv_clk_in;
         if (conv_clk_in && !pin_q) quiet_q <= 16'h0000;
         else if (quiet_q != 16'hffff) quiet_q <= quiet_q + 16'h0001;
      end
   end
   refresh_gap_a: assert property (refresh_out |-> quiet_q >= REFRESH_CYCLES)
      else $error("refresh too soon");
endmodule // aot_adc_checker

// file: sim/aot_host_capture.sv
// Host model capturing converter results as offset binary.
// Assumes the system clock and the block's status output.
`timescale 1ns/1ps
module aot_host_capture (
   input  wire        clock_in,
   input  wire        sys_rst_in,
   input  wire        acquiring_in,
   input  wire [13:0] result_in,
   output wire [13:0] offset_out
);
   reg        acq_q;
   reg [13:0] offset_q;
   assign offset_out = offset_q;
   // Latch on the status falling edge, sign bit inverted
   always @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         acq_q <= 1'b1;
         offset_q <= 14'h0000;
      end else begin
         acq_q <= acquiring_in;
         if (acq_q && !acquiring_in) offset_q <= {~result_in[13], result_in[12:0]};
      end
   end
endmodule // aot_host_capture

// file: sim/tb.sv
// Testbench for the converter output timing block.
// Assumes a 40 MHz clock and a shortened refresh count.
`timescale 1ns/1ps
module tb;
   reg         clock_in = 0, sys_rst_in = 1, conv_clk_in = 0;
   reg  [13:0] sample_in = 14'h0000, p1 = 0, p2 = 0, p3 = 0, p4 = 0;
   wire [13:0] res, ho;
   wire        fl, acq, rf;
   integer     fail_count = 0, compares = 0, n;
   always #12.5 clock_in = ~clock_in;
   aot_adc_output #(.REFRESH_CYCLES(50)) DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .conv_clk_in(conv_clk_in),
      .sample_in(sample_in), .result_bits_out(res), .out_of_range_flag_out(fl), .acquiring_out(acq), .refresh_out(rf));
   aot_host_capture host (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .acquiring_in(acq), .result_in(res), .offset_out(ho));
   task tick(input integer k);
      repeat (k) begin @(posedge clock_in); #1; end
   endtask
   task chk(input [63:0] nm, input [13:0] e, input [13:0] g);
      begin
         compares = compares + 1;
         if (e !== g) begin
            fail_count = fail_count + 1;
            $display("wrong value %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // One conversion; g adds a second start while busy, with another sample
   task conv(input [13:0] s, input g);
      begin
         sample_in = s;
         conv_clk_in = 1;
         tick(2);
         conv_clk_in = 0;
         tick(1);
         conv_clk_in = g;
         sample_in = g ? ~s : s;
         tick(2);
         chk("busy", 14'h0000, {13'h0, acq});
         conv_clk_in = 0;
         tick(6);
         {p4, p3, p2, p1} = {p3, p2, p1, s};
         chk("word", p3, res);
         chk("flag", {13'h0, p3 == 14'h2000 || p3 == 14'h1fff}, {13'h0, fl});
         chk("host", {~p4[13], p4[12:0]}, ho);
      end
   endtask
   task t_reset;
      begin
         chk("acq", 14'h0001, {13'h0, acq});
         chk("word", 14'h0000, res);
      end
   endtask
   task t_stream;
      begin
         conv(14'h2000, 0);
         conv(14'h1fff, 0);
         conv(14'h1ffe, 0);
         conv(14'h2001, 0);
         conv(14'h3fff, 0);
      end
   endtask
   task t_glitch;
      begin
         conv(14'h0aaa, 1);
         conv(14'h1555, 1);
         conv(14'h0000, 0);
         conv(14'h1fff, 0);
      end
   endtask
   task t_refresh;
      begin
         n = 0;
         repeat (70) begin tick(1); n = n + rf; end
         chk("refresh", 14'h0001, n[13:0]);
      end
   endtask
   // Reset in mid-run returns the result word and status to their reset values
   task t_rerun;
      begin
         sys_rst_in = 1;
         tick(2);
         sys_rst_in = 0;
         tick(2);
         chk("rstword", 14'h0000, res);
         chk("rstacq", 14'h0001, {13'h0, acq});
      end
   endtask
   task conclude;
      begin
         $display("fail_count %0d compares %0d", fail_count, compares);
         if (fail_count == 0 && compares > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   // Main sequence after 10 cycles of reset
   initial begin
      tick(10);
      sys_rst_in = 0;
      tick(2);
      t_reset;
      t_stream;
      t_glitch;
      t_refresh;
      t_rerun;
      conclude;
   end
   // Watchdog well beyond the 200 or so cycles the tests need
   initial begin
      #60000;
      fail_count = fail_count + 1;
      conclude;
   end
endmodule // tb
bind aot_adc_output aot_adc_checker #(.REFRESH_CYCLES(REFRESH_CYCLES)) chk_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
   .conv_clk_in(conv_clk_in), .result_bits_out(result_bits_out), .out_of_range_flag_out(out_of_range_flag_out),
   .acquiring_out(acquiring_out), .refresh_out(refresh_out));
